// ### inc/rx_sampler_pkg.sv
// Constants and types for the receive sampler control block
package rx_sampler_pkg;
    localparam int CLK_HZ        = 100000000;
    localparam int DIG_RATE_X10  = 486000;
    localparam int ANA_RATE_X10  = 400000;
    localparam int DIG_PERIOD    = CLK_HZ * 10 / DIG_RATE_X10;
    localparam int ANA_PERIOD    = CLK_HZ * 10 / ANA_RATE_X10;
    localparam int CNT_W         = 12;
    localparam int SMP_W         = 10;
    localparam int DATA_W        = 16;
    localparam int ADDR_W        = 2;
    localparam int CTL_W         = 4;
    localparam int FIFO_DEPTH    = 16;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_I    = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_Q    = 2'h2;
    localparam int ST_OVR        = 15;
    localparam int ST_IRQ        = 14;
    localparam logic [CTL_W-1:0] CTL_RESET    = 4'h0;
    localparam logic [CTL_W-1:0] ANALOG_CODE  = 4'ha;
    localparam logic [CTL_W-1:0] DIGITAL_CODE = 4'h5;

    typedef struct packed {
        logic fm_receive_enable;
        logic iq_receive_enable;
        logic fm_voice_enable;
        logic mode;
    } ctrl_t;

    typedef struct packed {
        logic [SMP_W-1:0] i;
        logic [SMP_W-1:0] q;
    } sample_t;

    typedef enum logic [1:0] {CV_IDLE, CV_BUSY, CV_HOLD} conv_t;

    typedef struct packed {
        ctrl_t             pend;
        ctrl_t             act;
        logic [CNT_W-1:0]  cnt;
        conv_t             cv;
        sample_t           hold;
        sample_t           smp;
        logic              irq;
        logic              ovr;
        logic              stb_n;
        logic              start;
        logic              load;
        logic [DATA_W-1:0] rdata;
        logic              oe_n;
        logic              i_en;
        logic              q_en;
        logic              mux;
        logic              qref;
        logic              fmx;
        logic              iqx;
        logic              ana;
        logic              dig;
    } state_t;
endpackage

// ### hw/baseband_rx_sampler_control.sv
// Receive sampler control: mode decode, sample cadence, sample FIFO, processor port
`timescale 1ns/10ps
module sample_fifo #(
    parameter int W     = 20,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } fst_t;
    fst_t q, d;
    logic push, pop;

    assign in_ready  = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data  = q.mem[q.rp];

    always_comb begin
        d    = q;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule // sample_fifo

`timescale 1ns/10ps
module baseband_rx_sampler_control #(
    parameter int DEPTH = rx_sampler_pkg::FIFO_DEPTH
) (
    input  wire logic                               MCLK,
    input  wire logic                               RST,
    input  wire logic                               CE,
    input  wire logic                               PROC_STROBE_N,
    input  wire logic                               PROC_CHIP_SELECT_N,
    input  wire logic                               PROC_READ_WRITE,
    input  wire logic [rx_sampler_pkg::ADDR_W-1:0]  PROC_ADDRESS,
    input  wire logic [rx_sampler_pkg::DATA_W-1:0]  PROC_DATA_IN,
    output logic      [rx_sampler_pkg::DATA_W-1:0]  PROC_DATA_OUT,
    output logic                                    PROC_DATA_OE_N,
    input  wire logic                               ADC_DONE,
    input  wire logic [rx_sampler_pkg::SMP_W-1:0]   ADC_I,
    input  wire logic [rx_sampler_pkg::SMP_W-1:0]   ADC_Q,
    output logic                                    CONV_START,
    output logic                                    I_POWER_EN,
    output logic                                    Q_POWER_EN,
    output logic                                    FM_MUX_SEL,
    output logic                                    QN_TO_REF,
    output logic                                    EXT_FM_RX_EN,
    output logic                                    EXT_IQ_RX_EN,
    output logic                                    MODE_ANALOG,
    output logic                                    MODE_DIGITAL,
    output logic                                    SAMPLE_READY_IRQ,
    output logic                                    OVERRUN
);
    localparam logic [rx_sampler_pkg::CNT_W-1:0] DIG_LAST =
        rx_sampler_pkg::CNT_W'(rx_sampler_pkg::DIG_PERIOD - 1);
    localparam logic [rx_sampler_pkg::CNT_W-1:0] ANA_LAST =
        rx_sampler_pkg::CNT_W'(rx_sampler_pkg::ANA_PERIOD - 1);

    rx_sampler_pkg::state_t  q, d;
    rx_sampler_pkg::sample_t fifo_out;
    logic sel, wr_rise, rd_rise, rd_act, tick, pop, f_valid, f_ready;
    logic [rx_sampler_pkg::CNT_W-1:0] last;

    sample_fifo #(.W($bits(rx_sampler_pkg::sample_t)), .DEPTH(DEPTH)) u_fifo (
        .clk       (MCLK),
        .rst       (RST),
        .ce        (CE),
        .in_valid  (q.cv == rx_sampler_pkg::CV_HOLD),
        .in_data   (q.hold),
        .in_ready  (f_ready),
        .out_valid (f_valid),
        .out_data  (fifo_out),
        .out_ready (pop)
    );

    always_comb begin
        d       = q;
        d.stb_n = PROC_STROBE_N;
        d.start = 1'b0;
        sel     = !PROC_CHIP_SELECT_N;
        // Strobe edges seen against last cycle's strobe level
        wr_rise = sel && !PROC_READ_WRITE && !q.stb_n && PROC_STROBE_N;
        rd_rise = sel && PROC_READ_WRITE && !q.stb_n && PROC_STROBE_N;
        rd_act  = sel && PROC_READ_WRITE && !PROC_STROBE_N;
        last    = q.act.mode ? DIG_LAST : ANA_LAST;
        tick    = q.cnt >= last;
        d.cnt   = tick ? '0 : q.cnt + 1'b1;

        // Captured only at strobe rise; select and address assumed steady
        if (wr_rise && PROC_ADDRESS == rx_sampler_pkg::ADDR_CTRL) begin
            d.pend = PROC_DATA_IN[rx_sampler_pkg::CTL_W-1:0];
            d.ovr  = 1'b0;
        end
        if (tick) begin
            d.act = q.pend;
        end

        case (q.cv)
            rx_sampler_pkg::CV_IDLE: begin
                if (tick && q.q_en) begin
                    d.start = 1'b1;
                    d.cv    = rx_sampler_pkg::CV_BUSY;
                end
            end
            rx_sampler_pkg::CV_BUSY: begin
                if (ADC_DONE) begin
                    // I path is powered down in analog mode, report zero
                    d.hold.i = q.i_en ? ADC_I : '0;
                    d.hold.q = ADC_Q;
                    d.cv     = rx_sampler_pkg::CV_HOLD;
                end
            end
            rx_sampler_pkg::CV_HOLD: begin
                if (f_ready) begin
                    d.cv = rx_sampler_pkg::CV_IDLE;
                end
            end
            default: d.cv = rx_sampler_pkg::CV_IDLE;
        endcase
        // A boundary missed while busy or holding drops that period; set beats clear
        if (tick && q.cv != rx_sampler_pkg::CV_IDLE) begin
            d.ovr = 1'b1;
        end

        // Next sample waits until the processor has finished reading Q
        pop = f_valid && (!q.irq || (rd_rise && PROC_ADDRESS == rx_sampler_pkg::ADDR_Q));
        if (rd_rise && PROC_ADDRESS == rx_sampler_pkg::ADDR_Q) begin
            d.irq = 1'b0;
        end
        d.load = pop;
        if (pop) begin
            d.smp = fifo_out;
            d.irq = 1'b1;
        end

        d.oe_n = !rd_act;
        case (PROC_ADDRESS)
            rx_sampler_pkg::ADDR_CTRL: begin
                d.rdata = '0;
                d.rdata[rx_sampler_pkg::CTL_W-1:0] = q.pend;
                d.rdata[rx_sampler_pkg::ST_OVR] = q.ovr;
                d.rdata[rx_sampler_pkg::ST_IRQ] = q.irq;
            end
            rx_sampler_pkg::ADDR_I: d.rdata = {{(rx_sampler_pkg::DATA_W - rx_sampler_pkg::SMP_W)
                {q.smp.i[rx_sampler_pkg::SMP_W-1]}}, q.smp.i};
            rx_sampler_pkg::ADDR_Q: d.rdata = {{(rx_sampler_pkg::DATA_W - rx_sampler_pkg::SMP_W)
                {q.smp.q[rx_sampler_pkg::SMP_W-1]}}, q.smp.q};
            default: d.rdata = '0;
        endcase

        // Enables follow the applied control, never the pending one
        d.i_en = d.act.mode && d.act.iq_receive_enable;
        d.q_en = d.act.mode ? d.act.iq_receive_enable : d.act.fm_voice_enable;
        d.mux  = d.act.fm_voice_enable;
        d.qref = d.act.fm_voice_enable;
        d.fmx  = !d.act.mode && d.act.fm_receive_enable;
        d.iqx  = d.act.mode && d.act.iq_receive_enable;
        d.ana  = d.act == rx_sampler_pkg::ANALOG_CODE;
        d.dig  = d.act == rx_sampler_pkg::DIGITAL_CODE;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            q       <= '0;
            q.stb_n <= 1'b1;
            q.oe_n  <= 1'b1;
        end else if (CE) begin
            q <= d;
        end
    end

    assign PROC_DATA_OUT    = q.rdata;
    assign PROC_DATA_OE_N   = q.oe_n;
    assign CONV_START       = q.start;
    assign I_POWER_EN       = q.i_en;
    assign Q_POWER_EN       = q.q_en;
    assign FM_MUX_SEL       = q.mux;
    assign QN_TO_REF        = q.qref;
    assign EXT_FM_RX_EN     = q.fmx;
    assign EXT_IQ_RX_EN     = q.iqx;
    assign MODE_ANALOG      = q.ana;
    assign MODE_DIGITAL     = q.dig;
    assign SAMPLE_READY_IRQ = q.irq;
    assign OVERRUN          = q.ovr;

    sequence s_load;
        CE && pop;
    endsequence
    sequence s_irq_up;
        SAMPLE_READY_IRQ && q.load;
    endsequence

    property p_irq_on_load;
        @(posedge MCLK) disable iff (RST) s_load |=> s_irq_up;
    endproperty
    a_irq_on_load: assert property (p_irq_on_load) else $error("irq not raised on load");

    property p_sample_loaded;
        @(posedge MCLK) disable iff (RST) s_load |=> q.smp == $past(fifo_out);
    endproperty
    a_sample_loaded: assert property (p_sample_loaded) else $error("sample register not loaded");

    property p_i_off_analog;
        @(posedge MCLK) disable iff (RST) !q.act.mode |-> !I_POWER_EN;
    endproperty
    a_i_off_analog: assert property (p_i_off_analog) else $error("I path on in analog mode");

    property p_both_on;
        @(posedge MCLK) disable iff (RST)
            (q.act.mode && q.act.iq_receive_enable) |-> (I_POWER_EN && Q_POWER_EN && EXT_IQ_RX_EN);
    endproperty
    a_both_on: assert property (p_both_on) else $error("digital enables missing");

    property p_q_voice;
        @(posedge MCLK) disable iff (RST)
            !q.act.mode |-> (Q_POWER_EN == q.act.fm_voice_enable && FM_MUX_SEL == QN_TO_REF);
    endproperty
    a_q_voice: assert property (p_q_voice) else $error("Q enable not following voice bit");

    property p_ext_fm;
        @(posedge MCLK) disable iff (RST) !q.act.mode |-> EXT_FM_RX_EN == q.act.fm_receive_enable;
    endproperty
    a_ext_fm: assert property (p_ext_fm) else $error("external FM enable wrong");

    property p_write_capture;
        @(posedge MCLK) disable iff (RST)
            (CE && wr_rise && PROC_ADDRESS == rx_sampler_pkg::ADDR_CTRL)
            |=> q.pend == $past(PROC_DATA_IN[rx_sampler_pkg::CTL_W-1:0]);
    endproperty
    a_write_capture: assert property (p_write_capture) else $error("write data not captured");

    property p_boundary;
        @(posedge MCLK) disable iff (RST) (q.act != $past(q.act)) |-> $past(tick);
    endproperty
    a_boundary: assert property (p_boundary) else $error("control applied off boundary");

    property p_period;
        @(posedge MCLK) disable iff (RST) (CE && tick) |-> q.cnt == last;
    endproperty
    a_period: assert property (p_period) else $error("sample period wrong");

    property p_sign;
        @(posedge MCLK) disable iff (RST)
            (CE && PROC_ADDRESS == rx_sampler_pkg::ADDR_Q)
            |=> PROC_DATA_OUT[rx_sampler_pkg::DATA_W-1] == $past(q.smp.q[rx_sampler_pkg::SMP_W-1]);
    endproperty
    a_sign: assert property (p_sign) else $error("read data not sign extended");

    sequence s_start;
        CE && CONV_START;
    endsequence

    property p_start_once;
        @(posedge MCLK) disable iff (RST) s_start |=> !CONV_START;
    endproperty
    a_start_once: assert property (p_start_once) else $error("start pulse too long");

    property p_mux_ref;
        @(posedge MCLK) disable iff (RST)
            FM_MUX_SEL == q.act.fm_voice_enable && QN_TO_REF == q.act.fm_voice_enable;
    endproperty
    a_mux_ref: assert property (p_mux_ref) else $error("input mux not following voice bit");

    property p_irq_clear;
        @(posedge MCLK) disable iff (RST)
            (CE && rd_rise && PROC_ADDRESS == rx_sampler_pkg::ADDR_Q && !pop) |=> !SAMPLE_READY_IRQ;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared by Q read");

    property p_modes;
        @(posedge MCLK) disable iff (RST)
            MODE_ANALOG == (q.act == rx_sampler_pkg::ANALOG_CODE)
            && MODE_DIGITAL == (q.act == rx_sampler_pkg::DIGITAL_CODE);
    endproperty
    a_modes: assert property (p_modes) else $error("mode flags wrong");

    // Powered-down I path must never leak converter noise
    property p_i_zero;
        @(posedge MCLK) disable iff (RST)
            (CE && q.cv == rx_sampler_pkg::CV_BUSY && ADC_DONE && !q.i_en) |=> q.hold.i == '0;
    endproperty
    a_i_zero: assert property (p_i_zero) else $error("I result not zero in analog mode");
endmodule // baseband_rx_sampler_control

// ### testbench/adc_model.sv
// Converter model answering each start pulse with an I/Q result pair
`timescale 1ns/10ps
module adc_model (
    input  wire logic                         clk,
    input  wire logic                         start,
    input  wire logic                         slow,
    output logic                              done,
    output logic [rx_sampler_pkg::SMP_W-1:0]  res_i,
    output logic [rx_sampler_pkg::SMP_W-1:0]  res_q
);
    int unsigned k = 0;

    initial begin
        done  = 1'b0;
        res_i = 10'h155;
        res_q = 10'h2aa;
        forever begin
            @(posedge clk);
            if (start === 1'b1) begin
                repeat (slow ? 40 : 3) @(negedge clk);
                done  = 1'b1;
                res_i = 10'(k * 37 + 5);
                res_q = 10'(k * 53 + 512);
                k++;
                @(negedge clk);
                done  = 1'b0;
                // Stale data is inverted so a late capture cannot pass
                res_i = ~res_i;
                res_q = ~res_q;
            end
        end
    end
endmodule // adc_model

// ### testbench/baseband_rx_sampler_control_test.sv
// Self-checking bench for the receive sampler control block
`timescale 1ns/10ps
module baseband_rx_sampler_control_test;
    logic                              clk = 1'b0, rst = 1'b1, stb_n = 1'b1, cs_n = 1'b1, rw = 1'b1, slow = 1'b0;
    logic                              ce = 1'b1;
    logic [rx_sampler_pkg::ADDR_W-1:0] addr = 2'h0;
    logic [rx_sampler_pkg::DATA_W-1:0] wdata = 16'h0, rdata;
    logic [rx_sampler_pkg::SMP_W-1:0]  adc_i, adc_q;
    logic                              oe_n, adc_done, conv_start, i_en, q_en, mux, qref, fmx, iqx, ana, dig, irq, ovr;
    int                                miscompares = 0, n_checks = 0, cyc = 0, last_start = 0, gap = 0, rd_k = 0;
    logic                              ion_q[$];

    always #5 clk = ~clk;

    // Remember I enable per conversion, since I reads as 0 when disabled
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1) begin
            gap <= cyc - last_start;
            last_start <= cyc;
            ion_q.push_back(i_en);
        end
    end

    baseband_rx_sampler_control #(.DEPTH(rx_sampler_pkg::FIFO_DEPTH)) i_dut (
        .MCLK(clk), .RST(rst), .CE(ce), .PROC_STROBE_N(stb_n), .PROC_CHIP_SELECT_N(cs_n),
        .PROC_READ_WRITE(rw), .PROC_ADDRESS(addr), .PROC_DATA_IN(wdata), .PROC_DATA_OUT(rdata),
        .PROC_DATA_OE_N(oe_n), .ADC_DONE(adc_done), .ADC_I(adc_i), .ADC_Q(adc_q), .CONV_START(conv_start),
        .I_POWER_EN(i_en), .Q_POWER_EN(q_en), .FM_MUX_SEL(mux), .QN_TO_REF(qref), .EXT_FM_RX_EN(fmx),
        .EXT_IQ_RX_EN(iqx), .MODE_ANALOG(ana), .MODE_DIGITAL(dig), .SAMPLE_READY_IRQ(irq), .OVERRUN(ovr));

    adc_model i_adc (.clk(clk), .start(conv_start), .slow(slow), .done(adc_done), .res_i(adc_i), .res_q(adc_q));

    function automatic logic [9:0] exp_i(input int k); return 10'(k * 37 + 5); endfunction
    function automatic logic [9:0] exp_q(input int k); return 10'(k * 53 + 512); endfunction
    function automatic logic [15:0] sx(input logic [9:0] s); return {{6{s[9]}}, s}; endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        rw = 1'b0;
        addr = a;
        wdata = d;
        stb_n = 1'b0;
        @(negedge clk);
        stb_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b1;
        rw = 1'b1;
    endtask

    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        int n;
        @(negedge clk);
        cs_n = 1'b0;
        rw = 1'b1;
        addr = a;
        stb_n = 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (oe_n !== 1'b0 && n < 8);
        check("read enable", 16'h0, {15'h0, oe_n});
        d = rdata;
        stb_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b1;
        @(negedge clk);
        check("read release", 16'h1, {15'h0, oe_n});
    endtask

    task automatic service(input logic clear_exp);
        int n;
        logic [15:0] di, dq;
        logic [9:0] ei;
        n = 0;
        while (irq !== 1'b1 && n < 6000) begin
            @(negedge clk);
            n++;
        end
        check("irq raised", 16'h1, {15'h0, irq});
        rd(rx_sampler_pkg::ADDR_I, di);
        rd(rx_sampler_pkg::ADDR_Q, dq);
        ei = (ion_q.size() > 0 && ion_q.pop_front() === 1'b1) ? exp_i(rd_k) : 10'h0;
        check("i sample", sx(ei), di);
        check("q sample", sx(exp_q(rd_k)), dq);
        rd_k++;
        if (clear_exp) check("irq cleared", 16'h0, {15'h0, irq});
    endtask

    task automatic wait_mode(input logic want_ana);
        int n;
        n = 0;
        while ((want_ana ? ana : dig) !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(90000 * 10);
        miscompares++;
        results();
    end

    initial begin
        logic [15:0] d;
        logic [3:0] code;
        int n_frz;
        void'($urandom(85318));
        repeat (12) @(negedge clk);
        check("reset outputs", 16'h0800, {4'h0, oe_n, conv_start, i_en, q_en, mux, qref, fmx, iqx, ana, dig, irq, ovr});
        rst = 1'b0;
        // Random control words, refused writes elsewhere, readback of pending bits
        for (int j = 0; j < 6; j++) begin
            code = 4'($urandom);
            wr(rx_sampler_pkg::ADDR_CTRL, {12'($urandom), code});
            wr(2'($urandom_range(3, 1)), 16'($urandom));
            rd(rx_sampler_pkg::ADDR_CTRL, d);
            check("control readback", {12'h0, code}, {2'b00, d[13:0]});
            rd(2'h3, d);
            check("unmapped read", 16'h0, d);
        end
        slow = 1'b1;
        wr(rx_sampler_pkg::ADDR_CTRL, {12'h0, rx_sampler_pkg::ANALOG_CODE});
        check("mode before boundary", 16'h0, {15'h0, ana});
        wait_mode(1'b1);
        check("analog outputs", 16'h007a, {8'h0, i_en, q_en, mux, qref, fmx, iqx, ana, dig});
        repeat (2) service(1'b1);
        check("analog period", 16'(rx_sampler_pkg::ANA_PERIOD), 16'(gap));
        slow = 1'b0;
        wr(rx_sampler_pkg::ADDR_CTRL, {12'h0, rx_sampler_pkg::DIGITAL_CODE});
        wait_mode(1'b0);
        check("digital outputs", 16'h00c5, {8'h0, i_en, q_en, mux, qref, fmx, iqx, ana, dig});
        repeat (3) service(1'b1);
        check("digital period", 16'(rx_sampler_pkg::DIG_PERIOD), 16'(gap));
        // Leave samples unread until the FIFO refuses and a boundary overruns
        repeat (20 * rx_sampler_pkg::DIG_PERIOD) @(negedge clk);
        check("overrun flag", 16'h1, {15'h0, ovr});
        rd(rx_sampler_pkg::ADDR_CTRL, d);
        check("status bits", 16'h3, {14'h0, d[15:14]});
        repeat (18) service(1'b0);
        wr(rx_sampler_pkg::ADDR_CTRL, {12'h0, rx_sampler_pkg::DIGITAL_CODE});
        check("overrun cleared", 16'h0, {15'h0, ovr});
        // Freeze only between start pulses, else a held pulse looks like many starts
        @(negedge clk);
        while (conv_start !== 1'b0) @(negedge clk);
        ce = 1'b0;
        n_frz = ion_q.size();
        repeat (2 * rx_sampler_pkg::DIG_PERIOD) @(negedge clk);
        check("frozen starts", 16'(n_frz), 16'(ion_q.size()));
        ce = 1'b1;
        results();
    end
endmodule // baseband_rx_sampler_control_test
